// [hdl/bscrc_pkg.sv]
/*
  Constants and carrier types for the byte stream checksum unit.
  Assumes a 32-bit Avalon-MM slave port with byte word addressing.
*/
// What this block does
// - Select bit picks 0x1021 or 0x04C11DB7 polynomial.
// - Init strobe presets whole result register.
// - Init value bit picks zeros or ones.
// - Each input byte write folds into result.
// - Result is 32 or 16 bits wide.
// - Pointer picks window byte, increments per access.
// - 32-bit mode pointer maps bytes 0 to 3.
// - 16-bit mode pointer wraps over two bytes.
// - Window write replaces byte, read returns it.
// - Result holds until preset, overwrite or input.
// - Bit reverse port reads back mirrored byte.
// - Control bits 7 to 5 read zero.
// - 16-bit step MSB-first with 0x1021.
// - 32-bit step reflected with 0xEDB88320.
package bscrc_pkg;
  localparam logic [7:0]  OFS_CONTROL = 8'h84;
  localparam logic [7:0]  OFS_INPUT   = 8'h85;
  localparam logic [7:0]  OFS_WINDOW  = 8'h86;
  localparam logic [7:0]  OFS_FLIP    = 8'hdf;
  localparam int          BIT_SEL     = 4;
  localparam int          BIT_INIT    = 3;
  localparam int          BIT_VAL     = 2;
  localparam logic [15:0] POLY16      = 16'h1021;
  localparam logic [31:0] POLY32      = 32'h04c1_1db7;
  localparam logic [31:0] POLY32_REFL = 32'hedb8_8320;
  localparam logic [31:0] PRESET_ONES = 32'hffff_ffff;
  localparam logic [31:0] PRESET_ZERO = 32'h0000_0000;
  localparam logic [7:0]  RESET_BYTE  = 8'h00;
  localparam logic [31:0] READ_ZERO   = 32'h0000_0000;

  typedef struct packed {
    logic [31:0] result;
    logic        sel16;
    logic        val_ones;
    logic [1:0]  ptr;
    logic [7:0]  in_byte;
    logic [7:0]  flip;
    logic [7:0]  rdata;
    logic        rvalid;
  } bscrc_state_s;
endpackage : bscrc_pkg

// [hdl/bscrc_top.sv]
/*
  Byte stream checksum unit with an Avalon-MM register slave.
  Assumes one clock, synchronous active-low reset, and a master that holds
  the request until waitrequest is seen low.
*/
`timescale 1ns/1ps
module bscrc_top (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        clk_en_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o
);
  bscrc_pkg::bscrc_state_s s_q;
  bscrc_pkg::bscrc_state_s s_d;
  logic                    wr_lo;
  logic                    rd_acc;

  // Fold one byte; both polynomials are unrolled over eight shifts.
  function automatic logic [31:0] fold(input logic [31:0] cur,
                                       input logic [7:0] din,
                                       input logic sel16);
    logic [31:0] a;
    logic [15:0] b;
    a = cur ^ {24'h00_0000, din};
    b = cur[15:0] ^ {din, 8'h00};
    for (int i = 0; i < 8; i++) begin
      a = a[0] ? ((a >> 1) ^ bscrc_pkg::POLY32_REFL) : (a >> 1);
      b = b[15] ? ((b << 1) ^ bscrc_pkg::POLY16) : (b << 1);
    end
    // The upper half is cleared in 16-bit mode so the result is 16 bits.
    fold = sel16 ? {16'h0000, b} : a;
  endfunction : fold

  // Maps pointer to byte lane; 16-bit mode ignores the pointer's high bit.
  function automatic logic [1:0] lane(input logic [1:0] p,
                                      input logic sel16);
    lane = sel16 ? {1'b0, p[0]} : p;
  endfunction : lane

  function automatic logic [7:0] mirror(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      mirror[i] = v[7-i];
    end
  endfunction : mirror

  // A write completes in one cycle, so waitrequest never rises while
  // idle; the read answer is registered, costing one wait cycle on reads.
  // A frozen clock would drop a write, so any request waits while the
  // enable is low.
  assign rd_acc            = avs_read_i && !s_q.rvalid;
  assign avs_waitrequest_o = rd_acc
                             || ((avs_read_i || avs_write_i) && !clk_en_i);
  assign avs_readdata_o    = {24'h00_0000, s_q.rdata};
  assign wr_lo             = avs_write_i && avs_byteenable_i[0];

  always_comb begin
    s_d        = s_q;
    s_d.rvalid = 1'b0;
    if (rd_acc) begin
      s_d.rvalid = 1'b1;
      case (avs_address_i)
        bscrc_pkg::OFS_CONTROL: begin
          // Init strobe is write-only and upper bits read zero.
          s_d.rdata = {3'b000, s_q.sel16, 1'b0, s_q.val_ones, s_q.ptr};
        end
        bscrc_pkg::OFS_INPUT: begin
          s_d.rdata = s_q.in_byte;
        end
        bscrc_pkg::OFS_WINDOW: begin
          s_d.rdata = s_q.result[8*lane(s_q.ptr, s_q.sel16) +: 8];
          s_d.ptr   = s_q.ptr + 2'd1;
        end
        bscrc_pkg::OFS_FLIP: begin
          s_d.rdata = mirror(s_q.flip);
        end
        default: begin
          s_d.rdata = bscrc_pkg::RESET_BYTE;
        end
      endcase
    end else if (wr_lo) begin
      case (avs_address_i)
        bscrc_pkg::OFS_CONTROL: begin
          s_d.sel16    = avs_writedata_i[bscrc_pkg::BIT_SEL];
          s_d.val_ones = avs_writedata_i[bscrc_pkg::BIT_VAL];
          s_d.ptr      = avs_writedata_i[1:0];
          if (avs_writedata_i[bscrc_pkg::BIT_INIT]) begin
            // New value bit from the same write is used for the preset.
            s_d.result = avs_writedata_i[bscrc_pkg::BIT_VAL]
                         ? bscrc_pkg::PRESET_ONES
                         : bscrc_pkg::PRESET_ZERO;
          end
        end
        bscrc_pkg::OFS_INPUT: begin
          s_d.in_byte = avs_writedata_i[7:0];
          s_d.result  = fold(s_q.result, avs_writedata_i[7:0],
                             s_q.sel16);
        end
        bscrc_pkg::OFS_WINDOW: begin
          s_d.result[8*lane(s_q.ptr, s_q.sel16) +: 8] =
            avs_writedata_i[7:0];
          s_d.ptr = s_q.ptr + 2'd1;
        end
        bscrc_pkg::OFS_FLIP: begin
          s_d.flip = avs_writedata_i[7:0];
        end
        default: begin
          s_d.flip = s_q.flip;
        end
      endcase
    end
  end

  // Result only changes on reset and on the decoded writes above.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  property p_poly16;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      clk_en_i && wr_lo && avs_address_i == bscrc_pkg::OFS_INPUT && s_q.sel16
      |=> s_q.result[31:16] == 16'h0000;
  endproperty
  a_poly16: assert property (p_poly16)
    else $error("16-bit high half set");

  property p_init;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      clk_en_i && wr_lo && avs_address_i == bscrc_pkg::OFS_CONTROL
      && avs_writedata_i[bscrc_pkg::BIT_INIT]
      |=> s_q.result == (s_q.val_ones ? bscrc_pkg::PRESET_ONES
                                      : bscrc_pkg::PRESET_ZERO);
  endproperty
  a_init: assert property (p_init) else $error("preset value wrong");

  property p_ptr;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      clk_en_i && (rd_acc || wr_lo) && avs_address_i == bscrc_pkg::OFS_WINDOW
      |=> s_q.ptr == $past(s_q.ptr) + 2'd1;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer not advanced");

  property p_flip;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      clk_en_i && rd_acc && avs_address_i == bscrc_pkg::OFS_FLIP
      |=> avs_readdata_o[0] == s_q.flip[7] && avs_readdata_o[7] == s_q.flip[0];
  endproperty
  a_flip: assert property (p_flip) else $error("flip order wrong");

  property p_ctl_zero;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      s_q.rvalid |-> avs_readdata_o[31:8] == 24'h00_0000;
  endproperty
  a_ctl_zero: assert property (p_ctl_zero)
    else $error("upper bits set");

  property p_hold;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      !wr_lo |=> s_q.result == $past(s_q.result);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed");

  property p_read_one;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      clk_en_i && avs_read_i && avs_waitrequest_o
      |=> !avs_waitrequest_o || !clk_en_i;
  endproperty
  a_read_one: assert property (p_read_one) else $error("read stall");

  property p_lane16;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      clk_en_i && rd_acc && avs_address_i == bscrc_pkg::OFS_WINDOW
      && s_q.sel16 && s_q.ptr == 2'd2 |=> avs_readdata_o[7:0]
      == $past(s_q.result[7:0]);
  endproperty
  a_lane16: assert property (p_lane16)
    else $error("16-bit lane wrong");

  // Register-level checks; all but the two waitrequest checks look one edge
  // after the access that they watch, when the registered state has settled.
  property p_wr_nowait;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      clk_en_i && avs_write_i |-> !avs_waitrequest_o;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait)
    else $error("write stalled");

  property p_stall;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      !clk_en_i && (avs_read_i || avs_write_i) |-> avs_waitrequest_o;
  endproperty
  a_stall: assert property (p_stall)
    else $error("request not held off");

  property p_freeze;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      !clk_en_i |=> s_q == $past(s_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while disabled");

  property p_in_echo;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      clk_en_i && wr_lo && avs_address_i == bscrc_pkg::OFS_INPUT
      |=> s_q.in_byte == $past(avs_writedata_i[7:0]);
  endproperty
  a_in_echo: assert property (p_in_echo)
    else $error("input byte not kept");

  property p_sel;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      clk_en_i && wr_lo && avs_address_i == bscrc_pkg::OFS_CONTROL
      |=> s_q.sel16 == $past(avs_writedata_i[bscrc_pkg::BIT_SEL]);
  endproperty
  a_sel: assert property (p_sel)
    else $error("select bit not loaded");

  property p_val;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      clk_en_i && wr_lo && avs_address_i == bscrc_pkg::OFS_CONTROL
      |=> s_q.val_ones == $past(avs_writedata_i[bscrc_pkg::BIT_VAL]);
  endproperty
  a_val: assert property (p_val)
    else $error("value bit not loaded");

  property p_no_init;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      clk_en_i && wr_lo && avs_address_i == bscrc_pkg::OFS_CONTROL
      && !avs_writedata_i[bscrc_pkg::BIT_INIT]
      |=> s_q.result == $past(s_q.result);
  endproperty
  a_no_init: assert property (p_no_init)
    else $error("result changed without strobe");

  property p_win_wr0;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      clk_en_i && wr_lo && avs_address_i == bscrc_pkg::OFS_WINDOW
      && s_q.ptr == 2'd0
      |=> s_q.result[7:0] == $past(avs_writedata_i[7:0]);
  endproperty
  a_win_wr0: assert property (p_win_wr0)
    else $error("window write lost");

  property p_lane32;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      clk_en_i && rd_acc && avs_address_i == bscrc_pkg::OFS_WINDOW
      && !s_q.sel16 && s_q.ptr == 2'd3
      |=> avs_readdata_o[7:0] == $past(s_q.result[31:24]);
  endproperty
  a_lane32: assert property (p_lane32)
    else $error("32-bit lane wrong");

  property p_ctl_read;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      clk_en_i && rd_acc && avs_address_i == bscrc_pkg::OFS_CONTROL
      |=> avs_readdata_o[7:5] == 3'b000 && !avs_readdata_o[3];
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("control read shows unused bits");

  property p_flip_wr;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      clk_en_i && wr_lo && avs_address_i == bscrc_pkg::OFS_FLIP
      |=> s_q.flip == $past(avs_writedata_i[7:0]);
  endproperty
  a_flip_wr: assert property (p_flip_wr)
    else $error("flip byte not stored");

  property p_reset;
    @(posedge core_clk_i)
      !rst_b_i |=> s_q == '0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("state not cleared by reset");

  property p_ptr_hold;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      clk_en_i && !rd_acc && !wr_lo |=> s_q.ptr == $past(s_q.ptr);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold)
    else $error("pointer moved while idle");

  property p_rvalid_one;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      clk_en_i && s_q.rvalid |=> !s_q.rvalid;
  endproperty
  a_rvalid_one: assert property (p_rvalid_one)
    else $error("read answer stood too long");

  property p_unmapped;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      clk_en_i && wr_lo && avs_address_i != bscrc_pkg::OFS_CONTROL
      && avs_address_i != bscrc_pkg::OFS_INPUT
      && avs_address_i != bscrc_pkg::OFS_WINDOW
      && avs_address_i != bscrc_pkg::OFS_FLIP
      |=> s_q == $past(s_q);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped write changed state");

  c_stall: cover property (@(posedge core_clk_i)
    !clk_en_i && avs_write_i);
  c_win_wr: cover property (@(posedge core_clk_i)
    wr_lo && avs_address_i == bscrc_pkg::OFS_WINDOW);
  c_fold: cover property (@(posedge core_clk_i)
    wr_lo && avs_address_i == bscrc_pkg::OFS_INPUT);
  c_win: cover property (@(posedge core_clk_i)
    rd_acc && avs_address_i == bscrc_pkg::OFS_WINDOW);
  c_flip: cover property (@(posedge core_clk_i)
    rd_acc && avs_address_i == bscrc_pkg::OFS_FLIP);
endmodule : bscrc_top

// [dv/bscrc_top_bench.sv]
/*
  Self-checking bench for the byte stream checksum unit.
  Assumes the unit's Avalon-MM slave: with the enable high, writes complete with no wait, reads
  with one wait cycle, and readdata valid at the completing edge.
*/
`timescale 1ns/1ps
module bscrc_top_bench;
  logic        core_clk_i;
  logic        rst_b_i;
  logic        clk_en_i;
  logic [7:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  int          failures;
  int          check_count;

  bscrc_top dut (
    .core_clk_i        (core_clk_i),
    .rst_b_i           (rst_b_i),
    .clk_en_i          (clk_en_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_byteenable_i  (avs_byteenable_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [7:0] a, input logic [31:0] got,
                     input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch reg %h expected %h seen %h", a, exp, got);
    end
  endtask : chk

  // The request is held until waitrequest is seen low, then one idle edge
  // passes so no signal is driven twice in a single time step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] be = 4'hf);
    avs_address_i    <= a;
    avs_writedata_i  <= {24'h00_0000, d};
    avs_byteenable_i <= be;
    avs_write_i      <= 1'b1;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    avs_address_i <= a;
    avs_read_i    <= 1'b1;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    chk(a, avs_readdata_o, {24'h00_0000, e});
    avs_read_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : rdchk

  // Four window reads from the current pointer, lowest byte of e first.
  task automatic rd4(input logic [31:0] e);
    for (int i = 0; i < 4; i++) begin
      rdchk(bscrc_pkg::OFS_WINDOW, e[8*i +: 8]);
    end
  endtask : rd4

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (4000) @(posedge core_clk_i);
    failures++;
    wrap_up();
  end

  initial begin
    failures         = 0;
    check_count      = 0;
    rst_b_i          = 1'b0;
    clk_en_i         = 1'b1;
    avs_address_i    = 8'h00;
    avs_read_i       = 1'b0;
    avs_write_i      = 1'b0;
    avs_writedata_i  = 32'h0000_0000;
    avs_byteenable_i = 4'hf;
    repeat (20) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rdchk(bscrc_pkg::OFS_CONTROL, 8'h00);
    rdchk(bscrc_pkg::OFS_INPUT, 8'h00);
    rdchk(bscrc_pkg::OFS_FLIP, 8'h00);
    rd4(32'h0000_0000);
    wr(bscrc_pkg::OFS_CONTROL, 8'hff);
    rdchk(bscrc_pkg::OFS_CONTROL, 8'h17);
    rd4(32'hffff_ffff);
    wr(bscrc_pkg::OFS_CONTROL, 8'h1c);
    wr(bscrc_pkg::OFS_INPUT, 8'h63);
    rdchk(bscrc_pkg::OFS_INPUT, 8'h63);
    rd4(32'hbd35_bd35);
    wr(bscrc_pkg::OFS_CONTROL, 8'h1c);
    wr(bscrc_pkg::OFS_INPUT, 8'haa);
    wr(bscrc_pkg::OFS_INPUT, 8'hbb);
    wr(bscrc_pkg::OFS_INPUT, 8'hcc);
    rd4(32'h6cf6_6cf6);
    wr(bscrc_pkg::OFS_CONTROL, 8'h0c);
    wr(bscrc_pkg::OFS_INPUT, 8'h63);
    rd4(32'hf946_2090);
    wr(bscrc_pkg::OFS_CONTROL, 8'h0c);
    wr(bscrc_pkg::OFS_INPUT, 8'haa);
    wr(bscrc_pkg::OFS_INPUT, 8'hbb);
    wr(bscrc_pkg::OFS_INPUT, 8'hcc);
    rd4(32'h41b2_07b3);
    wr(bscrc_pkg::OFS_CONTROL, 8'h08);
    rd4(32'h0000_0000);
    wr(bscrc_pkg::OFS_WINDOW, 8'h12);
    wr(bscrc_pkg::OFS_WINDOW, 8'h34);
    wr(bscrc_pkg::OFS_WINDOW, 8'h56);
    wr(bscrc_pkg::OFS_WINDOW, 8'h78);
    rdchk(bscrc_pkg::OFS_CONTROL, 8'h00);
    wr(bscrc_pkg::OFS_FLIP, 8'hc0);
    rdchk(bscrc_pkg::OFS_FLIP, 8'h03);
    rd4(32'h7856_3412);
    wr(bscrc_pkg::OFS_FLIP, 8'h05);
    rdchk(bscrc_pkg::OFS_FLIP, 8'ha0);
    // A write with byte lane zero disabled must leave the port untouched.
    wr(bscrc_pkg::OFS_FLIP, 8'hff, 4'he);
    rdchk(bscrc_pkg::OFS_FLIP, 8'ha0);
    wr(8'h90, 8'hff);
    rdchk(8'h90, 8'h00);
    rd4(32'h7856_3412);
    // A mid-run reset must return the control and result registers to zero.
    rst_b_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rdchk(bscrc_pkg::OFS_CONTROL, 8'h00);
    rd4(32'h0000_0000);
    wr(bscrc_pkg::OFS_CONTROL, 8'h10);
    rdchk(bscrc_pkg::OFS_CONTROL, 8'h10);
    wr(bscrc_pkg::OFS_CONTROL, 8'h14);
    wr(bscrc_pkg::OFS_CONTROL, 8'h1c);
    // An input write held off by a low enable must still be folded in.
    clk_en_i <= 1'b0;
    fork
      wr(bscrc_pkg::OFS_INPUT, 8'h63);
      begin
        repeat (3) @(posedge core_clk_i);
        clk_en_i <= 1'b1;
      end
    join
    rd4(32'hbd35_bd35);
    wrap_up();
  end
endmodule : bscrc_top_bench
